/* File: fcpes_defs.svh */
// Constants for the flash cache program, erase and status host controller.
`ifndef FCPES_DEFS_SVH
`define FCPES_DEFS_SVH
`define FCPES_CMD_PROG_SETUP 8'h80
`define FCPES_CMD_PROG_CONFIRM 8'h10
`define FCPES_CMD_CACHE_CONFIRM 8'h15
`define FCPES_CMD_ERASE_SETUP 8'h60
`define FCPES_CMD_ERASE_CONFIRM 8'hD0
`define FCPES_CMD_STATUS 8'h70
`define FCPES_CMD_RESET 8'hFF
`define FCPES_MAX_BYTES 12'd2112
`define FCPES_MAX_PAGES 7'd64
`define FCPES_BIT_WP 7
`define FCPES_BIT_DUAL 6
`define FCPES_BIT_CTRL 5
`define FCPES_BIT_PREV 1
`define FCPES_BIT_ERR 0
`define FCPES_CLK_MHZ 100
`define FCPES_STROBE_NS 30
`define FCPES_STROBE_CYC ((`FCPES_STROBE_NS * `FCPES_CLK_MHZ + 999) / 1000)
`endif

/* File: fcpes_dev_model.sv */
// Behavioural flash device answering program, cache program, erase, reset and status cycles.
`timescale 1ns/100ps
module fcpes_dev_model #(
  parameter int XFER_NS = 400,
  parameter int PROG_NS = 3000,
  parameter int ERASE_NS = 4000,
  parameter int RST_LONG_NS = 1500,
  parameter int RST_SHORT_NS = 200
) (
  input wire logic chip_enable_n_in,
  input wire logic cmd_latch_in,
  input wire logic addr_latch_in,
  input wire logic write_enable_n_in,
  input wire logic read_enable_n_in,
  input wire logic [7:0] io_drv_in,
  input wire logic io_oe_n_in,
  input wire logic protect_in,
  input wire logic fail_in,
  output logic [7:0] io_out,
  output logic ready_busy_out = 1'b1,
  output logic [7:0] n_addr_out = 8'h00,
  output logic [7:0] n_data_out = 8'h00,
  output logic [7:0] sum_out = 8'h00
);
  logic dual = 1'b1;
  logic ctrl = 1'b1;
  logic prev = 1'b0;
  logic err = 1'b0;
  logic stat_mode = 1'b0;
  logic was_reset = 1'b0;
  logic rst_long = 1'b0;
  logic fq = 1'b0;
  logic f;
  logic [7:0] job = 8'h00;
  logic [7:0] cur;
  logic [7:0] held = 8'h00;
  logic [7:0] stat;
  logic [7:0] na = 8'h00;
  logic [7:0] nd = 8'h00;
  logic [7:0] sum = 8'h00;
  assign stat = {~protect_in, dual, ctrl, 3'b000, prev, err};
  // Off the bus the lines show the inverse of the last value, so a stale sample cannot pass.
  assign io_out = (!chip_enable_n_in && !read_enable_n_in && stat_mode) ? stat : ~held;
  always @(stat or read_enable_n_in or chip_enable_n_in) if (!read_enable_n_in && !chip_enable_n_in) held = stat;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic take(input logic [7:0] c);
    stat_mode = (c == 8'h70);
    if (c == 8'h80 || c == 8'h60) begin
      was_reset = 1'b0;
      na = 8'h00;
      nd = 8'h00;
      sum = 8'h00;
    end else if ((c == 8'h10 || c == 8'h15 || c == 8'hD0) && !protect_in) begin
      was_reset = 1'b0;
      n_addr_out = na;
      n_data_out = nd;
      sum_out = sum;
      ready_busy_out = 1'b0;
      dual = 1'b0;
      ctrl = 1'b0;
      fq = fail_in;
      job = c;
    end else if (c == 8'hFF && !was_reset) begin
      rst_long = !ctrl;
      disable engine;
      ready_busy_out = 1'b0;
      dual = 1'b0;
      ctrl = 1'b0;
      prev = 1'b0;
      err = 1'b0;
      job = c;
    end
  endtask
  always @(posedge write_enable_n_in) begin
    if (!chip_enable_n_in && !io_oe_n_in) begin
      if (cmd_latch_in && (ready_busy_out || io_drv_in == 8'h70 || io_drv_in == 8'hFF)) begin
        take(io_drv_in);
      end else if (addr_latch_in) begin
        na = na + 8'h01;
      end else if (!cmd_latch_in) begin
        nd = nd + 8'h01;
        sum = sum ^ io_drv_in;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One engine runs jobs in order, so a cache page waits for the pending array program.
  always begin : engine
    wait (job != 8'h00);
    cur = job;
    f = fq;
    job = 8'h00;
    if (cur == 8'h15) begin
      #(XFER_NS);
      ready_busy_out = 1'b1;
      dual = 1'b1;
    end
    if (cur == 8'hFF) #(rst_long ? RST_LONG_NS : RST_SHORT_NS);
    else #(cur == 8'hD0 ? ERASE_NS : PROG_NS);
    was_reset = (cur == 8'hFF);
    prev = (cur == 8'h15 || cur == 8'h10) ? err : 1'b0;
    err = (cur == 8'hFF) ? 1'b0 : f;
    ctrl = (job == 8'h00);
    if (cur != 8'h15) ready_busy_out = 1'b1;
    if (cur != 8'h15) dual = 1'b1;
  end
endmodule

/* File: fcpes_host.sv */
// Host controller driving cache program, block erase, reset and status read cycles on a flash device.
`timescale 1ns/100ps
`include "fcpes_defs.svh"
module fcpes_host (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire fcpes_pkg::fcpes_op_t op_in,
  input wire logic start_in,
  input wire logic last_page_in,
  input wire logic [2:0] addr_cycles_in,
  input wire logic [39:0] addr_in,
  input wire logic [11:0] byte_count_in,
  input wire logic data_valid_in,
  input wire logic [7:0] data_in,
  output logic data_ready_out,
  output logic busy_out,
  output logic done_out,
  output logic refused_out,
  output logic [7:0] status_out,
  output logic chip_enable_n_out,
  output logic cmd_latch_out,
  output logic addr_latch_out,
  output logic write_enable_n_out,
  output logic read_enable_n_out,
  output logic [7:0] io_out,
  output logic io_oe_n_out,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_in
);
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [3:0] STROBE_CYC = 4'(`FCPES_STROBE_CYC);
  fcpes_pkg::fcpes_state_t state, next_state;
  fcpes_pkg::fcpes_op_t op, next_op;
  logic [3:0] tick, next_tick;
  logic phase, next_phase;
  logic [7:0] cmd, next_cmd;
  logic [2:0] acnt, next_acnt;
  logic [39:0] addr, next_addr;
  logic [11:0] bcnt, next_bcnt;
  logic [6:0] pages, next_pages;
  logic last, next_last;
  logic [7:0] status, next_status;
  logic [7:0] io, next_io;
  logic done, next_done;
  logic refused, next_refused;
  logic cl, next_cl;
  logic al, next_al;
  logic we_n, next_we_n;
  logic re_n, next_re_n;
  logic oe_n, next_oe_n;
  logic strobe_end;
  assign strobe_end = (tick == STROBE_CYC) && phase;
  assign data_ready_out = (state == fcpes_pkg::FCPES_ST_DATA) && !phase && (tick == 4'h0);
  assign busy_out = (state != fcpes_pkg::FCPES_ST_IDLE);
  assign done_out = done;
  assign refused_out = refused;
  assign status_out = status;
  assign chip_enable_n_out = (state == fcpes_pkg::FCPES_ST_IDLE);
  assign cmd_latch_out = cl;
  assign addr_latch_out = al;
  assign write_enable_n_out = we_n;
  assign read_enable_n_out = re_n;
  assign io_out = io;
  assign io_oe_n_out = oe_n;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_op = op;
    next_tick = tick;
    next_phase = phase;
    next_cmd = cmd;
    next_acnt = acnt;
    next_addr = addr;
    next_bcnt = bcnt;
    next_pages = pages;
    next_last = last;
    next_status = status;
    next_io = io;
    next_done = 1'b0;
    next_refused = 1'b0;
    next_cl = cl;
    next_al = al;
    next_we_n = we_n;
    next_re_n = re_n;
    next_oe_n = oe_n;
    if (state != fcpes_pkg::FCPES_ST_IDLE) begin
      next_tick = (tick == STROBE_CYC) ? 4'h0 : tick + 4'h1;
      if (tick == STROBE_CYC) begin
        next_phase = !phase;
      end
    end
    case (state)
      fcpes_pkg::FCPES_ST_IDLE: begin
        next_tick = 4'h0;
        next_phase = 1'b0;
        if (start_in) begin
          next_op = op_in;
          next_addr = addr_in;
          next_acnt = addr_cycles_in;
          next_bcnt = (byte_count_in > `FCPES_MAX_BYTES) ? `FCPES_MAX_BYTES : byte_count_in;
          next_last = last_page_in || (op_in == fcpes_pkg::FCPES_OP_CACHE && pages == `FCPES_MAX_PAGES - 7'd1);
          next_state = fcpes_pkg::FCPES_ST_CMD;
          next_oe_n = 1'b0;
          next_cl = 1'b1;
          next_we_n = 1'b0;
          case (op_in)
            fcpes_pkg::FCPES_OP_PROG, fcpes_pkg::FCPES_OP_CACHE: begin
              next_cmd = `FCPES_CMD_PROG_SETUP;
              if (!status[`FCPES_BIT_WP]) begin
                next_state = fcpes_pkg::FCPES_ST_IDLE;
                next_refused = 1'b1;
              end
            end
            fcpes_pkg::FCPES_OP_ERASE: begin
              next_cmd = `FCPES_CMD_ERASE_SETUP;
              next_acnt = (addr_cycles_in > 3'd3) ? 3'd3 : addr_cycles_in;
              if (!status[`FCPES_BIT_WP]) begin
                next_state = fcpes_pkg::FCPES_ST_IDLE;
                next_refused = 1'b1;
              end
            end
            fcpes_pkg::FCPES_OP_STATUS: next_cmd = `FCPES_CMD_STATUS;
            fcpes_pkg::FCPES_OP_RESET: next_cmd = `FCPES_CMD_RESET;
            default: begin
              next_state = fcpes_pkg::FCPES_ST_IDLE;
              next_refused = 1'b1;
            end
          endcase
          if (next_state == fcpes_pkg::FCPES_ST_IDLE) begin
            next_oe_n = 1'b1;
            next_cl = 1'b0;
            next_we_n = 1'b1;
          end
          next_io = next_cmd;
        end
      end
      fcpes_pkg::FCPES_ST_CMD, fcpes_pkg::FCPES_ST_ADDR, fcpes_pkg::FCPES_ST_DATA, fcpes_pkg::FCPES_ST_CONF: begin
        if (tick == STROBE_CYC && !phase) begin
          next_we_n = 1'b1;
        end
        if (strobe_end) begin
          next_cl = 1'b0;
          next_al = 1'b0;
          next_we_n = 1'b0;
          if (state == fcpes_pkg::FCPES_ST_CONF || (state == fcpes_pkg::FCPES_ST_CMD
              && (op == fcpes_pkg::FCPES_OP_STATUS || op == fcpes_pkg::FCPES_OP_RESET))) begin
            next_we_n = 1'b1;
            next_oe_n = 1'b1;
            next_state = (op == fcpes_pkg::FCPES_OP_STATUS) ? fcpes_pkg::FCPES_ST_POLL : fcpes_pkg::FCPES_ST_WAIT;
          end else if (acnt != 3'd0) begin
            next_al = 1'b1;
            next_io = addr[7:0];
            next_addr = {8'h00, addr[39:8]};
            next_acnt = acnt - 3'd1;
            next_state = fcpes_pkg::FCPES_ST_ADDR;
          end else if (op != fcpes_pkg::FCPES_OP_ERASE && bcnt != 12'd0) begin
            next_we_n = 1'b1;
            next_state = fcpes_pkg::FCPES_ST_DATA;
          end else begin
            next_cl = 1'b1;
            next_state = fcpes_pkg::FCPES_ST_CONF;
            if (op == fcpes_pkg::FCPES_OP_ERASE) begin
              next_io = `FCPES_CMD_ERASE_CONFIRM;
            end else if (op == fcpes_pkg::FCPES_OP_CACHE && !last) begin
              next_io = `FCPES_CMD_CACHE_CONFIRM;
            end else begin
              next_io = `FCPES_CMD_PROG_CONFIRM;
            end
          end
        end
        if (state == fcpes_pkg::FCPES_ST_DATA && !phase && tick == 4'h0) begin
          if (data_valid_in) begin
            next_io = data_in;
            next_we_n = 1'b0;
            next_bcnt = bcnt - 12'd1;
          end else begin
            next_tick = 4'h0;
          end
        end
      end
      fcpes_pkg::FCPES_ST_WAIT: begin
        next_tick = 4'h0;
        if (ready_busy_in && tick == 4'h0 && phase == 1'b0) begin
          if (op == fcpes_pkg::FCPES_OP_CACHE && !last) begin
            next_pages = pages + 7'd1;
            next_done = 1'b1;
            next_state = fcpes_pkg::FCPES_ST_IDLE;
          end else if (op == fcpes_pkg::FCPES_OP_RESET) begin
            next_pages = 7'd0;
            next_done = 1'b1;
            next_state = fcpes_pkg::FCPES_ST_IDLE;
          end else begin
            next_cmd = `FCPES_CMD_STATUS;
            next_io = `FCPES_CMD_STATUS;
            next_oe_n = 1'b0;
            next_cl = 1'b1;
            next_we_n = 1'b0;
            next_op = fcpes_pkg::FCPES_OP_STATUS;
            next_pages = 7'd0;
            next_state = fcpes_pkg::FCPES_ST_CMD;
          end
        end
      end
      fcpes_pkg::FCPES_ST_POLL: begin
        next_re_n = 1'b0;
        if (strobe_end) begin
          next_status = {io_in[7:5], 3'b000, io_in[1:0]};
          if (io_in[`FCPES_BIT_CTRL]) begin
            next_re_n = 1'b1;
            next_done = 1'b1;
            next_state = fcpes_pkg::FCPES_ST_IDLE;
          end
        end
      end
      default: next_state = fcpes_pkg::FCPES_ST_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state <= fcpes_pkg::FCPES_ST_IDLE;
      op <= fcpes_pkg::FCPES_OP_STATUS;
      tick <= 4'h0;
      phase <= 1'b0;
      cmd <= 8'h00;
      acnt <= 3'd0;
      addr <= 40'h00_0000_0000;
      bcnt <= 12'h000;
      pages <= 7'd0;
      last <= 1'b0;
      status <= 8'h80;
      io <= 8'h00;
      done <= 1'b0;
      refused <= 1'b0;
      cl <= 1'b0;
      al <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      tick <= next_tick;
      phase <= next_phase;
      cmd <= next_cmd;
      acnt <= next_acnt;
      addr <= next_addr;
      bcnt <= next_bcnt;
      pages <= next_pages;
      last <= next_last;
      status <= next_status;
      io <= next_io;
      done <= next_done;
      refused <= next_refused;
      cl <= next_cl;
      al <= next_al;
      we_n <= next_we_n;
      re_n <= next_re_n;
      oe_n <= next_oe_n;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_page_limit;
    @(posedge clock_in) disable iff (reset_in) pages <= `FCPES_MAX_PAGES;
  endproperty
  a_page_limit: assert property (p_page_limit) else $error("too many cached pages");
  property p_reserved_zero;
    @(posedge clock_in) disable iff (reset_in) status[4:2] == 3'b000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits set");
  property p_protect_refuse;
    @(posedge clock_in) disable iff (reset_in)
      (state == fcpes_pkg::FCPES_ST_IDLE && start_in && !status[`FCPES_BIT_WP]
       && op_in == fcpes_pkg::FCPES_OP_ERASE) |=> refused && state == fcpes_pkg::FCPES_ST_IDLE;
  endproperty
  a_protect_refuse: assert property (p_protect_refuse) else $error("protected erase not refused");
  sequence s_confirm_issued;
    state == fcpes_pkg::FCPES_ST_CONF && !we_n;
  endsequence
  property p_erase_confirm;
    @(posedge clock_in) disable iff (reset_in)
      s_confirm_issued and op == fcpes_pkg::FCPES_OP_ERASE |-> cl && io == `FCPES_CMD_ERASE_CONFIRM;
  endproperty
  a_erase_confirm: assert property (p_erase_confirm) else $error("wrong erase confirm");
  property p_last_plain;
    @(posedge clock_in) disable iff (reset_in)
      s_confirm_issued and last && op == fcpes_pkg::FCPES_OP_CACHE |-> io == `FCPES_CMD_PROG_CONFIRM;
  endproperty
  a_last_plain: assert property (p_last_plain) else $error("last page not plain confirm");
  property p_data_limit;
    @(posedge clock_in) disable iff (reset_in) bcnt <= `FCPES_MAX_BYTES;
  endproperty
  a_data_limit: assert property (p_data_limit) else $error("data count too large");
endmodule

/* File: fcpes_pkg.sv */
// Types for the flash cache program, erase and status host controller.
package fcpes_pkg;
  typedef enum logic [7:0] {
    FCPES_OP_PROG = 8'h01,
    FCPES_OP_CACHE = 8'h02,
    FCPES_OP_ERASE = 8'h04,
    FCPES_OP_STATUS = 8'h08,
    FCPES_OP_RESET = 8'h10
  } fcpes_op_t;
  typedef enum logic [6:0] {
    FCPES_ST_IDLE = 7'h01,
    FCPES_ST_CMD = 7'h02,
    FCPES_ST_ADDR = 7'h04,
    FCPES_ST_DATA = 7'h08,
    FCPES_ST_CONF = 7'h10,
    FCPES_ST_WAIT = 7'h20,
    FCPES_ST_POLL = 7'h40
  } fcpes_state_t;
endpackage

/* File: tb_top.sv */
// Self-checking bench for the flash host controller against a behavioural flash device.
`timescale 1ns/100ps
module tb_top;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  fcpes_pkg::fcpes_op_t op_in = fcpes_pkg::FCPES_OP_STATUS;
  logic start_in, last_page_in, data_valid_in, data_ready_out, busy_out, done_out, refused_out;
  logic chip_enable_n_out, cmd_latch_out, addr_latch_out, write_enable_n_out, read_enable_n_out;
  logic io_oe_n_out, ready_busy_in, protect, fail, saw_busy, got_ref;
  logic [2:0] addr_cycles_in, ac;
  logic [39:0] addr_in;
  logic [11:0] byte_count_in;
  logic [7:0] data_in, status_out, io_out, io_in, dev_addr, dev_data, dev_sum, exp_sum, nb;
  logic [31:0] rnd = 32'h2e38_79b8;
  int n_errors = 0;
  int checks = 0;
  int i;
  always #5 clock_in = ~clock_in;
  fcpes_host i_dut (.clock_in, .reset_in, .op_in, .start_in, .last_page_in, .addr_cycles_in, .addr_in,
    .byte_count_in, .data_valid_in, .data_in, .data_ready_out, .busy_out, .done_out, .refused_out,
    .status_out, .chip_enable_n_out, .cmd_latch_out, .addr_latch_out, .write_enable_n_out,
    .read_enable_n_out, .io_out, .io_oe_n_out, .io_in, .ready_busy_in);
  fcpes_dev_model i_dev (.chip_enable_n_in(chip_enable_n_out), .cmd_latch_in(cmd_latch_out),
    .addr_latch_in(addr_latch_out), .write_enable_n_in(write_enable_n_out), .read_enable_n_in(read_enable_n_out),
    .io_drv_in(io_out), .io_oe_n_in(io_oe_n_out), .protect_in(protect), .fail_in(fail), .io_out(io_in),
    .ready_busy_out(ready_busy_in), .n_addr_out(dev_addr), .n_data_out(dev_data), .sum_out(dev_sum));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_stat(input logic wp_ok, input logic e);
    return {wp_ok, 1'b1, 1'b1, 4'h0, e};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Random stalls on the byte offer exercise the data handshake.
  always @(posedge clock_in) begin
    rnd <= lfsr(rnd);
    data_valid_in <= rnd[3] | rnd[6];
    if (data_ready_out === 1'b1 && data_valid_in) exp_sum <= exp_sum ^ data_in;
    if (data_ready_out === 1'b1 && data_valid_in) data_in <= rnd[15:8];
  end
  always @(negedge ready_busy_in) saw_busy = 1'b1;
  task automatic run_op(input fcpes_pkg::fcpes_op_t op, input logic last, input logic [2:0] acy,
      input logic [7:0] n, input logic [39:0] addr);
    int k;
    @(posedge clock_in);
    op_in <= op;
    last_page_in <= last;
    addr_cycles_in <= acy;
    byte_count_in <= {4'h0, n};
    addr_in <= addr;
    start_in <= 1'b1;
    exp_sum <= 8'h00;
    saw_busy = 1'b0;
    got_ref = 1'b0;
    @(posedge clock_in);
    start_in <= 1'b0;
    for (k = 0; k < 20000 && done_out !== 1'b1 && refused_out !== 1'b1; k++) @(negedge clock_in);
    // The refusal pulse lasts one cycle, so it is caught here while it stands.
    if (refused_out === 1'b1) got_ref = 1'b1;
    chk("op_finished", 8'h01, 8'(k < 20000));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    start_in = 1'b0;
    last_page_in = 1'b0;
    addr_cycles_in = 3'd4;
    addr_in = 40'h00_0000_0000;
    byte_count_in = 12'h000;
    data_valid_in = 1'b0;
    data_in = 8'h00;
    exp_sum = 8'h00;
    protect = 1'b0;
    fail = 1'b0;
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    @(negedge clock_in);
    chk("status_reset", 8'h80, status_out);
    run_op(fcpes_pkg::FCPES_OP_STATUS, 1'b0, 3'd4, 8'h00, addr_in);
    chk("status_idle", exp_stat(1'b1, 1'b0), status_out);
    for (i = 0; i < 2; i++) begin
      fail = i[0];
      ac = i[0] ? 3'd2 : 3'd5;
      run_op(fcpes_pkg::FCPES_OP_ERASE, 1'b0, ac, 8'h00, {rnd, rnd[7:0]});
      chk("erase_status", exp_stat(1'b1, i[0]), status_out);
      chk("erase_addr_cycles", i[0] ? 8'h02 : 8'h03, dev_addr);
      chk("erase_busy_seen", 8'h01, {7'h00, saw_busy});
    end
    fail = 1'b0;
    run_op(fcpes_pkg::FCPES_OP_PROG, 1'b0, 3'd5, 8'h08, {rnd, rnd[7:0]});
    chk("prog_status", exp_stat(1'b1, 1'b0), status_out & 8'hFD);
    chk("prog_bytes", 8'h08, dev_data);
    // Pages stay in block zero and the last page ends with the plain confirm.
    for (i = 0; i < 4; i++) begin
      nb = 8'h01 + {5'h00, rnd[2:0]};
      ac = 3'd4 + {2'b00, rnd[9]};
      fail = (i == 3);
      run_op(fcpes_pkg::FCPES_OP_CACHE, i == 3, ac, nb, {16'h0000, 8'(i), 16'h0000});
      chk("cache_bytes", nb, dev_data);
      chk("cache_sum", exp_sum, dev_sum);
      chk("cache_addr_cycles", {5'h00, ac}, dev_addr);
      chk("cache_busy_seen", 8'h01, {7'h00, saw_busy});
    end
    chk("cache_end_status", exp_stat(1'b1, 1'b1), status_out & 8'hFD);
    run_op(fcpes_pkg::FCPES_OP_RESET, 1'b0, 3'd4, 8'h00, addr_in);
    chk("reset_busy_seen", 8'h01, {7'h00, saw_busy});
    run_op(fcpes_pkg::FCPES_OP_RESET, 1'b0, 3'd4, 8'h00, addr_in);
    chk("reset_repeat_busy", 8'h00, {7'h00, saw_busy});
    run_op(fcpes_pkg::FCPES_OP_STATUS, 1'b0, 3'd4, 8'h00, addr_in);
    chk("status_after_reset", exp_stat(1'b1, 1'b0), status_out);
    protect = 1'b1;
    run_op(fcpes_pkg::FCPES_OP_STATUS, 1'b0, 3'd4, 8'h00, addr_in);
    chk("status_protected", exp_stat(1'b0, 1'b0), status_out);
    run_op(fcpes_pkg::FCPES_OP_ERASE, 1'b0, 3'd3, 8'h00, addr_in);
    chk("erase_refused", 8'h01, {7'h00, got_ref});
    protect = 1'b0;
    run_op(fcpes_pkg::FCPES_OP_STATUS, 1'b0, 3'd4, 8'h00, addr_in);
    chk("status_unprotected", exp_stat(1'b1, 1'b0), status_out);
    close_out();
  end
  initial begin
    #(32'h000F_4240);
    n_errors++;
    $display("BAD watchdog expected finish got hang");
    close_out();
  end
endmodule
